// ==== rtl/qbp_defs.svh ====
// Constants for the quasi-bidirectional port and strobed bus block
`ifndef QBP_DEFS_SVH
`define QBP_DEFS_SVH
`define QBP_PORT_W 8
`define QBP_NUM_QPORTS 2
`define QBP_NUM_TESTS 3
`define QBP_LATCH_RST 8'hFF
`define QBP_BUS_RST 8'h00
`define QBP_CLK_MHZ 200
`define QBP_MCYCLE_NS 2500
`define QBP_SPU_NS (`QBP_MCYCLE_NS / 5)
`define QBP_SPU_CYC ((`QBP_SPU_NS * `QBP_CLK_MHZ) / 1000)
`define QBP_STB_NS 400
`define QBP_STB_CYC ((`QBP_STB_NS * `QBP_CLK_MHZ + 999) / 1000)
`define QBP_SETUP_CYC 1
`define QBP_HOLD_CYC 1
`define QBP_CNT_W 8
`endif

// ==== rtl/qbp_pkg.sv ====
// Types shared by the port block
package qbp_pkg;
   typedef enum logic [2:0] {
      QBP_PORT_WRITE_OP,
      QBP_PORT_READ_OP,
      QBP_PORT_OR_MODIFY_OP,
      QBP_PORT_AND_MODIFY_OP,
      QBP_STATIC_PORT_OUTPUT_OP,
      QBP_STATIC_BUS_INPUT_OP,
      QBP_EXTERNAL_DATA_WRITE_OP,
      QBP_EXTERNAL_DATA_READ_OP
   } qbp_op_type;
   typedef enum logic [1:0] {
      QBP_BUS_IDLE,
      QBP_BUS_SETUP,
      QBP_BUS_STROBE,
      QBP_BUS_HOLD
   } qbp_bus_state_type;
endpackage

// ==== rtl/qbp_quasi_port.sv ====
// One quasi-bidirectional port: latch, pin sync and strong pull-up pulse
`timescale 1ns/1ps
`include "qbp_defs.svh"
module qbp_quasi_port import qbp_pkg::*; #(
   parameter int PORT_W = `QBP_PORT_W,
   parameter int SPU_CYC = `QBP_SPU_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [PORT_W-1:0] wr_data_i,
   input wire logic [PORT_W-1:0] pin_i,
   output logic [PORT_W-1:0] pin_sync_o,
   output logic [PORT_W-1:0] latch_o,
   output logic [PORT_W-1:0] pin_o,
   output logic [PORT_W-1:0] pin_oe_o
);
   localparam logic [`QBP_CNT_W-1:0] SPU_LOAD = `QBP_CNT_W'(SPU_CYC);
   logic [PORT_W-1:0] meta_q;
   logic [PORT_W-1:0] sync_q;
   logic [PORT_W-1:0] latch_q;
   logic [`QBP_CNT_W-1:0] spu_cnt_q;
   logic spu_on;

   // Pins are asynchronous to the core clock
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_i) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         latch_q <= `QBP_LATCH_RST;
      end else if (ce_i && wr_i) begin
         latch_q <= wr_data_i;
      end
   end

   // Every write restarts the pulse, unchanged data or not
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         spu_cnt_q <= '0;
      end else if (ce_i) begin
         if (wr_i) begin
            spu_cnt_q <= SPU_LOAD;
         end else if (spu_on) begin
            spu_cnt_q <= spu_cnt_q - 1'b1;
         end
      end
   end
   assign spu_on = (spu_cnt_q != '0);

   // Weak pull-up is passive; only strong drivers appear here
   genvar b;
   generate
      for (b = 0; b < PORT_W; b++) begin : g_line
         assign pin_o[b] = latch_q[b];
         assign pin_oe_o[b] = !latch_q[b] || spu_on;
      end
   endgenerate
   assign pin_sync_o = sync_q;
   assign latch_o = latch_q;

   property p_spu_len;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      wr_i |=> spu_cnt_q == SPU_LOAD;
   endproperty
   a_spu_len: assert property (p_spu_len) else $error("pull-up pulse not loaded");

   property p_spu_drive;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      wr_i |=> (pin_oe_o & pin_o) == $past(wr_data_i);
   endproperty
   a_spu_drive: assert property (p_spu_drive) else $error("ones not driven high");

   property p_zero_low;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (latch_q != '1) |-> ((pin_oe_o & ~pin_o) == ~latch_q);
   endproperty
   a_zero_low: assert property (p_zero_low) else $error("zero line not pulled low");
endmodule // qbp_quasi_port

// ==== rtl/qbp_io_top.sv ====
// Quasi-bidirectional ports, strobed bus port and test inputs
`timescale 1ns/1ps
`include "qbp_defs.svh"
module qbp_io_top import qbp_pkg::*; #(
   parameter int PORT_W = `QBP_PORT_W,
   parameter int NUM_TESTS = `QBP_NUM_TESTS,
   parameter int SPU_CYC = `QBP_SPU_CYC,
   parameter int STB_CYC = `QBP_STB_CYC,
   parameter int SETUP_CYC = `QBP_SETUP_CYC,
   parameter int HOLD_CYC = `QBP_HOLD_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic op_valid_i,
   input wire qbp_op_type op_code_i,
   input wire logic port_sel_i,
   input wire logic [PORT_W-1:0] op_data_i,
   output logic op_ready_o,
   output logic [PORT_W-1:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic [PORT_W-1:0] p1_pin_i,
   output logic [PORT_W-1:0] p1_pin_o,
   output logic [PORT_W-1:0] p1_pin_oe_o,
   input wire logic [PORT_W-1:0] p2_pin_i,
   output logic [PORT_W-1:0] p2_pin_o,
   output logic [PORT_W-1:0] p2_pin_oe_o,
   input wire logic [PORT_W-1:0] bus_pin_i,
   output logic [PORT_W-1:0] bus_pin_o,
   output logic bus_oe_o,
   output logic rd_b_o,
   output logic wr_b_o,
   input wire logic [NUM_TESTS-1:0] test_pin_i,
   output logic [NUM_TESTS-1:0] test_level_o
);
   localparam int NQ = `QBP_NUM_QPORTS;
   localparam logic [`QBP_CNT_W-1:0] SETUP_LOAD = `QBP_CNT_W'(SETUP_CYC - 1);
   localparam logic [`QBP_CNT_W-1:0] STB_LOAD = `QBP_CNT_W'(STB_CYC - 1);
   localparam logic [`QBP_CNT_W-1:0] HOLD_LOAD = `QBP_CNT_W'(HOLD_CYC - 1);
   localparam logic [`QBP_CNT_W-1:0] STB_LEN = `QBP_CNT_W'(STB_CYC);

   logic accept;
   logic is_quasi_op;
   logic is_bus_op;
   logic bus_wr_op;
   logic [NQ-1:0] q_wr;
   logic [PORT_W-1:0] q_wr_data;
   logic [PORT_W-1:0] sel_pins;
   logic [NQ-1:0][PORT_W-1:0] q_pin_in;
   logic [NQ-1:0][PORT_W-1:0] q_sync;
   logic [NQ-1:0][PORT_W-1:0] q_latch;
   logic [NQ-1:0][PORT_W-1:0] q_pin_out;
   logic [NQ-1:0][PORT_W-1:0] q_pin_oe;

   logic [PORT_W-1:0] bus_meta_q;
   logic [PORT_W-1:0] bus_sync_q;
   logic [NUM_TESTS-1:0] test_meta_q;
   logic [NUM_TESTS-1:0] test_sync_q;

   qbp_bus_state_type bus_st_q;
   logic [`QBP_CNT_W-1:0] bus_cnt_q;
   logic bus_cnt_done;
   logic bus_wr_q;
   logic static_out_q;
   logic [PORT_W-1:0] bus_out_q;
   logic bus_oe_q;
   logic rd_b_q;
   logic wr_b_q;
   logic [PORT_W-1:0] rd_data_q;
   logic rd_valid_q;
   logic [`QBP_CNT_W-1:0] wr_low_cnt_q;

   // Operation decode; bus ops stall the op port until the hold phase ends
   assign op_ready_o = (bus_st_q == QBP_BUS_IDLE);
   assign accept = op_valid_i && op_ready_o && ce_i;
   assign is_quasi_op = (op_code_i == QBP_PORT_WRITE_OP) ||
                        (op_code_i == QBP_PORT_READ_OP) ||
                        (op_code_i == QBP_PORT_OR_MODIFY_OP) ||
                        (op_code_i == QBP_PORT_AND_MODIFY_OP);
   assign is_bus_op = !is_quasi_op;
   assign bus_wr_op = (op_code_i == QBP_STATIC_PORT_OUTPUT_OP) ||
                      (op_code_i == QBP_EXTERNAL_DATA_WRITE_OP);
   assign sel_pins = q_sync[port_sel_i];

   // Modify ops read the pins, not the latch
   always_comb begin
      case (op_code_i)
         QBP_PORT_OR_MODIFY_OP: q_wr_data = sel_pins | op_data_i;
         QBP_PORT_AND_MODIFY_OP: q_wr_data = sel_pins & op_data_i;
         default: q_wr_data = op_data_i;
      endcase
   end

   assign q_pin_in[0] = p1_pin_i;
   assign q_pin_in[1] = p2_pin_i;

   genvar g;
   generate
      for (g = 0; g < NQ; g++) begin : g_qport
         assign q_wr[g] = accept && is_quasi_op && (port_sel_i == 1'(g)) &&
                          (op_code_i != QBP_PORT_READ_OP);
         qbp_quasi_port #(
            .PORT_W(PORT_W),
            .SPU_CYC(SPU_CYC)
         ) u_qport (
            .ref_clk_i(ref_clk_i),
            .rst_b_i(rst_b_i),
            .ce_i(ce_i),
            .wr_i(q_wr[g]),
            .wr_data_i(q_wr_data),
            .pin_i(q_pin_in[g]),
            .pin_sync_o(q_sync[g]),
            .latch_o(q_latch[g]),
            .pin_o(q_pin_out[g]),
            .pin_oe_o(q_pin_oe[g])
         );
      end
   endgenerate

   assign p1_pin_o = q_pin_out[0];
   assign p1_pin_oe_o = q_pin_oe[0];
   assign p2_pin_o = q_pin_out[1];
   assign p2_pin_oe_o = q_pin_oe[1];

   // Bus and test pins come from outside the clock domain
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         bus_meta_q <= '0;
         bus_sync_q <= '0;
         test_meta_q <= '0;
         test_sync_q <= '0;
      end else if (ce_i) begin
         bus_meta_q <= bus_pin_i;
         bus_sync_q <= bus_meta_q;
         test_meta_q <= test_pin_i;
         test_sync_q <= test_meta_q;
      end
   end
   assign test_level_o = test_sync_q;

   assign bus_cnt_done = (bus_cnt_q == '0);

   // Bus strobe sequencer: setup, strobe low, hold after trailing edge
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         bus_st_q <= QBP_BUS_IDLE;
         bus_cnt_q <= '0;
         bus_wr_q <= 1'b0;
      end else if (ce_i) begin
         case (bus_st_q)
            QBP_BUS_IDLE: begin
               if (accept && is_bus_op) begin
                  bus_st_q <= QBP_BUS_SETUP;
                  bus_cnt_q <= SETUP_LOAD;
                  bus_wr_q <= bus_wr_op;
               end
            end
            QBP_BUS_SETUP: begin
               if (bus_cnt_done) begin
                  bus_st_q <= QBP_BUS_STROBE;
                  bus_cnt_q <= STB_LOAD;
               end else begin
                  bus_cnt_q <= bus_cnt_q - 1'b1;
               end
            end
            QBP_BUS_STROBE: begin
               if (bus_cnt_done) begin
                  bus_st_q <= QBP_BUS_HOLD;
                  bus_cnt_q <= HOLD_LOAD;
               end else begin
                  bus_cnt_q <= bus_cnt_q - 1'b1;
               end
            end
            QBP_BUS_HOLD: begin
               if (bus_cnt_done) begin
                  bus_st_q <= QBP_BUS_IDLE;
               end else begin
                  bus_cnt_q <= bus_cnt_q - 1'b1;
               end
            end
            default: begin
               bus_st_q <= QBP_BUS_IDLE;
               bus_cnt_q <= '0;
            end
         endcase
      end
   end

   // Both static ops pulse their strobe too, though loads seldom use it
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         rd_b_q <= 1'b1;
         wr_b_q <= 1'b1;
      end else if (ce_i) begin
         if (bus_st_q == QBP_BUS_SETUP && bus_cnt_done) begin
            rd_b_q <= bus_wr_q;
            wr_b_q <= !bus_wr_q;
         end else if (bus_st_q == QBP_BUS_STROBE && bus_cnt_done) begin
            rd_b_q <= 1'b1;
            wr_b_q <= 1'b1;
         end
      end
   end
   assign rd_b_o = rd_b_q;
   assign wr_b_o = wr_b_q;

   // Static mode is whole-port; any later bus op other than a static output leaves it
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         static_out_q <= 1'b0;
         bus_out_q <= `QBP_BUS_RST;
      end else if (accept && is_bus_op) begin
         static_out_q <= (op_code_i == QBP_STATIC_PORT_OUTPUT_OP);
         if (bus_wr_op) begin
            bus_out_q <= op_data_i;
         end
      end
   end

   // Drivers on only for a write in flight or a static output latch
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         bus_oe_q <= 1'b0;
      end else if (ce_i) begin
         if (accept && is_bus_op) begin
            bus_oe_q <= bus_wr_op;
         end else if (bus_st_q == QBP_BUS_HOLD && bus_cnt_done) begin
            bus_oe_q <= static_out_q;
         end
      end
   end
   assign bus_oe_o = bus_oe_q;
   assign bus_pin_o = bus_out_q;

   // Read data from sampled pins; bus read taken at the trailing edge
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         rd_data_q <= '0;
         rd_valid_q <= 1'b0;
      end else if (ce_i) begin
         rd_valid_q <= 1'b0;
         if (accept && op_code_i == QBP_PORT_READ_OP) begin
            rd_data_q <= sel_pins;
            rd_valid_q <= 1'b1;
         end else if (bus_st_q == QBP_BUS_STROBE && bus_cnt_done && !bus_wr_q) begin
            rd_data_q <= bus_sync_q;
            rd_valid_q <= 1'b1;
         end
      end
   end
   assign rd_data_o = rd_data_q;
   assign rd_valid_o = rd_valid_q;

   // Checks
   property p_latch_rst;
      @(posedge ref_clk_i)
      $rose(rst_b_i) |-> (q_latch[0] == `QBP_LATCH_RST) && (q_latch[1] == `QBP_LATCH_RST);
   endproperty
   a_latch_rst: assert property (p_latch_rst) else $error("latch not ones after reset");

   property p_latch_hold;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !q_wr[0] |=> $stable(q_latch[0]);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

   property p_or_modify;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      (accept && op_code_i == QBP_PORT_OR_MODIFY_OP) |=>
         q_latch[$past(port_sel_i)] == ($past(sel_pins) | $past(op_data_i));
   endproperty
   a_or_modify: assert property (p_or_modify) else $error("OR write-back wrong");

   property p_rmw_pulse;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      (accept && op_code_i == QBP_PORT_AND_MODIFY_OP && port_sel_i == 1'b0) |=>
         (p1_pin_oe_o & p1_pin_o) == q_latch[0];
   endproperty
   a_rmw_pulse: assert property (p_rmw_pulse) else $error("write-back pulse missing");

   property p_quasi_read;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      (accept && op_code_i == QBP_PORT_READ_OP) |=>
         rd_valid_o && rd_data_o == $past(sel_pins);
   endproperty
   a_quasi_read: assert property (p_quasi_read) else $error("port read not from pins");

   property p_strobe_excl;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !(!rd_b_o && !wr_b_o);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");

   property p_wr_trail;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      $rose(wr_b_o) |-> bus_oe_o && $stable(bus_pin_o);
   endproperty
   a_wr_trail: assert property (p_wr_trail) else $error("write data not held at trailing edge");

   property p_rd_capture;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      $rose(rd_b_o) |-> rd_valid_o && rd_data_o == $past(bus_sync_q) && !bus_oe_o;
   endproperty
   a_rd_capture: assert property (p_rd_capture) else $error("bus read not captured at edge");

   property p_bus_float;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (bus_st_q == QBP_BUS_IDLE && !static_out_q) |-> !bus_oe_o;
   endproperty
   a_bus_float: assert property (p_bus_float) else $error("bus driven while idle");

   // Strobe widths run to dozens of cycles, so count them rather than unroll
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         wr_low_cnt_q <= '0;
      end else if (ce_i) begin
         if (wr_b_q) begin
            wr_low_cnt_q <= '0;
         end else begin
            wr_low_cnt_q <= wr_low_cnt_q + 1'b1;
         end
      end
   end

   property p_strobe_len;
      @(posedge ref_clk_i) disable iff (!rst_b_i || !ce_i)
      $rose(wr_b_o) |-> wr_low_cnt_q == STB_LEN;
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("write strobe width wrong");
endmodule // qbp_io_top

// ==== testbench/qbp_ext_model.sv ====
// Outside logic model: pull-ups, pulling gates and a bus peripheral
`timescale 1ns/1ps
module qbp_ext_model #(
   parameter int PORT_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic [PORT_W-1:0] q1_out_i,
   input wire logic [PORT_W-1:0] q1_oe_i,
   input wire logic [PORT_W-1:0] q1_low_i,
   input wire logic [PORT_W-1:0] q2_out_i,
   input wire logic [PORT_W-1:0] q2_oe_i,
   input wire logic [PORT_W-1:0] q2_low_i,
   input wire logic [PORT_W-1:0] bus_out_i,
   input wire logic bus_oe_i,
   input wire logic dev_sel_i,
   input wire logic [PORT_W-1:0] dev_data_i,
   output logic [PORT_W-1:0] q1_pin_o,
   output logic [PORT_W-1:0] q2_pin_o,
   output logic [PORT_W-1:0] bus_pin_o
);
   logic [PORT_W-1:0] bus_last_q = '0;
   // Strong drive wins, weak pull-up yields to outside gates held until read
   assign q1_pin_o = (q1_oe_i & q1_out_i) | (~q1_oe_i & ~q1_low_i);
   assign q2_pin_o = (q2_oe_i & q2_out_i) | (~q2_oe_i & ~q2_low_i);
   always_comb begin
      if (bus_oe_i) begin
         bus_pin_o = bus_out_i;
      end else if (dev_sel_i) begin
         bus_pin_o = dev_data_i;
      end else begin
         // Floating bus: toggle so a stale value never passes
         bus_pin_o = ~bus_last_q;
      end
   end
   always @(posedge ref_clk_i) begin
      bus_last_q <= bus_pin_o;
   end
endmodule // qbp_ext_model

// ==== testbench/quasi_bidir_ports_and_strobed_bus_tb.sv ====
// Self-checking bench for the quasi ports and strobed bus
`timescale 1ns/1ps
module quasi_bidir_ports_and_strobed_bus_tb import qbp_pkg::*;;
   localparam int SPU = 4;
   localparam int STB = 2;
   localparam int TMAX = 20000;
   localparam qbp_op_type BUS_OPS [5] = '{QBP_EXTERNAL_DATA_WRITE_OP,
      QBP_EXTERNAL_DATA_READ_OP, QBP_STATIC_PORT_OUTPUT_OP,
      QBP_EXTERNAL_DATA_WRITE_OP, QBP_STATIC_BUS_INPUT_OP};
   logic ref_clk_i, rst_b_i, ce_i, op_valid_i, port_sel_i;
   qbp_op_type op_code_i;
   logic [7:0] op_data_i, rd_data_o, p1_pin_i, p1_pin_o, p1_pin_oe_o;
   logic [7:0] p2_pin_i, p2_pin_o, p2_pin_oe_o, bus_pin_i, bus_pin_o;
   logic op_ready_o, rd_valid_o, bus_oe_o, rd_b_o, wr_b_o, dev_sel;
   logic [2:0] test_pin_i, test_level_o;
   logic [7:0] q1_low, q2_low, dev_data;
   logic [31:0] rnd;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   qbp_io_top #(.SPU_CYC(SPU), .STB_CYC(STB), .SETUP_CYC(1), .HOLD_CYC(1)) qbp_io_top_i (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .op_valid_i(op_valid_i),
      .op_code_i(op_code_i), .port_sel_i(port_sel_i), .op_data_i(op_data_i),
      .op_ready_o(op_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o), .p1_pin_oe_o(p1_pin_oe_o),
      .p2_pin_i(p2_pin_i), .p2_pin_o(p2_pin_o), .p2_pin_oe_o(p2_pin_oe_o),
      .bus_pin_i(bus_pin_i), .bus_pin_o(bus_pin_o), .bus_oe_o(bus_oe_o),
      .rd_b_o(rd_b_o), .wr_b_o(wr_b_o), .test_pin_i(test_pin_i),
      .test_level_o(test_level_o));

   qbp_ext_model qbp_ext_model_i (
      .ref_clk_i(ref_clk_i), .q1_out_i(p1_pin_o), .q1_oe_i(p1_pin_oe_o),
      .q1_low_i(q1_low), .q2_out_i(p2_pin_o), .q2_oe_i(p2_pin_oe_o), .q2_low_i(q2_low),
      .bus_out_i(bus_pin_o), .bus_oe_i(bus_oe_o), .dev_sel_i(dev_sel),
      .dev_data_i(dev_data), .q1_pin_o(p1_pin_i), .q2_pin_o(p2_pin_i),
      .bus_pin_o(bus_pin_i));

   task summarize;
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk_i) begin
      cyc = cyc + 1;
      if (cyc == TMAX) begin
         error_cnt++;
         $display("Error at %0t: run timed out", $time);
         summarize();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp, input string what);
      samples_checked++;
      if (got != exp) begin
         error_cnt++;
         $display("Error at %0t: %s count %0d exp %0d", $time, what, got, exp);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] rnd8();
      rnd = lfsr(rnd);
      return rnd[7:0];
   endfunction

   function automatic logic [7:0] exp_mod(qbp_op_type c, logic [7:0] pins, logic [7:0] opnd);
      return (c == QBP_PORT_OR_MODIFY_OP) ? (pins | opnd) : (pins & opnd);
   endfunction

   task automatic step(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         #1;
      end
   endtask

   // Leaves valid high so callers may chain ops back to back
   task automatic do_op(input qbp_op_type c, input logic s, input logic [7:0] d);
      int n;
      n = 0;
      op_code_i = c;
      port_sel_i = s;
      op_data_i = d;
      op_valid_i = 1'b1;
      while (op_ready_o !== 1'b1 && n < 50) begin
         step(1);
         n++;
      end
      chk_cnt(n < 50, 1, "op accept");
      step(1);
   endtask

   task automatic quasi_wr(qbp_op_type c, logic s, logic [7:0] d, logic [7:0] e);
      do_op(c, s, d);
      op_valid_i = 1'b0;
      chk8(s ? p2_pin_o : p1_pin_o, e, "latch");
      chk8(s ? p2_pin_oe_o : p1_pin_oe_o, 8'hFF, "pulse start");
      step(SPU - 1);
      chk8(s ? p2_pin_oe_o : p1_pin_oe_o, 8'hFF, "pulse last");
      step(1);
      chk8(s ? p2_pin_oe_o : p1_pin_oe_o, ~e, "pulse end");
   endtask

   task automatic quasi_rd(logic s, logic [7:0] e);
      do_op(QBP_PORT_READ_OP, s, 8'h00);
      op_valid_i = 1'b0;
      chk8({7'h00, rd_valid_o}, 8'h01, "read valid");
      chk8(rd_data_o, e, "port read");
   endtask

   task automatic run_bus(qbp_op_type c, logic [7:0] d);
      int n, wl, rl, oe_rd;
      logic pw, wr;
      wr = (c == QBP_EXTERNAL_DATA_WRITE_OP) || (c == QBP_STATIC_PORT_OUTPUT_OP);
      n = 0;
      wl = 0;
      rl = 0;
      oe_rd = 0;
      pw = 1'b1;
      dev_data = d;
      dev_sel = !wr;
      do_op(c, 1'b0, d);
      op_valid_i = 1'b0;
      while (op_ready_o !== 1'b1 && n < 40) begin
         if (wr_b_o === 1'b0) wl++;
         if (rd_b_o === 1'b0) rl++;
         if (!wr && bus_oe_o !== 1'b0) oe_rd++;
         if (pw === 1'b0 && wr_b_o === 1'b1) chk8(bus_oe_o === 1'b1 ? bus_pin_o : ~d, d, "held data");
         pw = wr_b_o;
         step(1);
         n++;
      end
      dev_sel = 1'b0;
      chk_cnt(wl, wr ? STB : 0, "write strobe");
      chk_cnt(rl, wr ? 0 : STB, "read strobe");
      chk_cnt(oe_rd, 0, "driven in read");
      if (!wr) chk8(rd_data_o, d, "bus read");
      if (wr) chk8(bus_pin_o, d, "bus out");
      chk8({7'h00, bus_oe_o}, {7'h00, c == QBP_STATIC_PORT_OUTPUT_OP}, "drive after");
   endtask

   initial begin
      logic s;
      logic [7:0] d, x, e, d2;
      qbp_op_type c;
      rnd = 32'h71910B28;
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      op_valid_i = 1'b0;
      op_code_i = QBP_PORT_WRITE_OP;
      port_sel_i = 1'b0;
      op_data_i = 8'h00;
      q1_low = 8'h00;
      q2_low = 8'h00;
      dev_sel = 1'b0;
      dev_data = 8'h00;
      test_pin_i = 3'h0;
      repeat (6) @(posedge ref_clk_i);
      #1;
      rst_b_i = 1'b1;
      chk8(p1_pin_o & p2_pin_o, 8'hFF, "reset latch");
      chk8(p1_pin_oe_o | p2_pin_oe_o, 8'h00, "reset drive");
      chk8({5'h00, bus_oe_o, rd_b_o, wr_b_o}, 8'h03, "reset bus");
      // Pin synchronisers were cleared by reset; let them refill
      step(3);
      quasi_rd(1'b0, 8'hFF);
      quasi_rd(1'b1, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         x = rnd8();
         s = x[0];
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd8();
         quasi_wr(QBP_PORT_WRITE_OP, s, d, d);
         x = rnd8();
         if (s) q2_low = x; else q1_low = x;
         step(3);
         e = d & ~x;
         quasi_rd(s, e);
         c = i[0] ? QBP_PORT_OR_MODIFY_OP : QBP_PORT_AND_MODIFY_OP;
         d2 = rnd8();
         quasi_wr(c, s, d2, exp_mod(c, e, d2));
         step(3);
         quasi_rd(s, exp_mod(c, e, d2) & ~x);
         q1_low = 8'h00;
         q2_low = 8'h00;
         test_pin_i = x[3:1];
         step(3);
         chk8({5'h00, test_level_o}, {5'h00, x[3:1]}, "test level");
      end
      // Back-to-back: second write must restart the pulse
      do_op(QBP_PORT_WRITE_OP, 1'b0, 8'hFF);
      do_op(QBP_PORT_OR_MODIFY_OP, 1'b0, 8'hFF);
      op_valid_i = 1'b0;
      step(SPU - 1);
      chk8(p1_pin_oe_o, 8'hFF, "pulse refire");
      step(1);
      chk8(p1_pin_oe_o, 8'h00, "pulse over");
      // Clock enable low must freeze the pulse count
      do_op(QBP_PORT_WRITE_OP, 1'b0, 8'h0F);
      op_valid_i = 1'b0;
      ce_i = 1'b0;
      step(5);
      chk8(p1_pin_oe_o, 8'hFF, "pulse frozen");
      ce_i = 1'b1;
      step(SPU);
      chk8(p1_pin_oe_o, 8'hF0, "pulse thawed");
      for (int k = 0; k < 10; k++) begin
         run_bus(BUS_OPS[k % 5], (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd8());
      end
      summarize();
   end
endmodule // quasi_bidir_ports_and_strobed_bus_tb
